// ===== rtl/rcs_pkg.sv
// Summary of operation
// - core clock is 2, 3 or 4 times input
// - link clock is core divided by 1..4
// - serial clock is core divided by programmable ratio
// - external port switches at input clock rate
// - reset deasserts strobes, three-states pins within one input clock
// - suspend, host request, memory space ignored in reset
// - early host request remembered, grant after bus sync
// - core reset held 4096 input clocks after release
// - missed setup may add one input clock
package rcs_pkg;
  // ==========================================================
  // register map
  localparam int unsigned AXI_ADDR_W = 8;
  localparam logic [7:0] ADDR_SYSCFG = 8'h00;
  localparam logic [7:0] ADDR_SERDIV0 = 8'h04;
  localparam logic [7:0] ADDR_SERDIV1 = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [31:0] SYSCFG_RESET = 32'h0000_0000;
  localparam logic [31:0] SERDIV_RESET = 32'h0000_0000;
  localparam int unsigned SOFT_RST_BIT = 0;
  localparam int unsigned LINK_DIV_LSB = 4;
  localparam int unsigned LINK_DIV_W = 2;
  localparam int unsigned NUM_LINK = 2;
  localparam int unsigned SER_DIV_W = 16;
  localparam int unsigned NUM_SER = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // clock ratio pin codes and ratios
  localparam logic [1:0] CFG_RATIO2 = 2'h0;
  localparam logic [1:0] CFG_RATIO3 = 2'h1;
  localparam logic [2:0] RATIO2 = 3'h2;
  localparam logic [2:0] RATIO3 = 3'h3;
  localparam logic [2:0] RATIO4 = 3'h4;
  // ==========================================================
  // timing counts, in input clocks; reset sync stages in core clocks
  localparam int unsigned CORE_RST_TICKS = 4096;
  localparam int unsigned BUS_SYNC_TICKS = 4;
  localparam int unsigned RST_SYNC_STAGES = 2;
  // ==========================================================
  // pin groups
  typedef struct packed {
    logic [3:0] memSelN;
    logic rdN;
    logic wrN;
    logic [1:0] dmaGrantN;
    logic cacheFetchN;
    logic page;
    logic burst;
  } rcs_strobe_t;
  localparam rcs_strobe_t STROBE_IDLE = '{memSelN: 4'hf, rdN: 1'b1, wrN: 1'b1, dmaGrantN: 2'h3,
                                          cacheFetchN: 1'b1, page: 1'b0, burst: 1'b0};
  typedef struct packed {
    logic [3:0] flagEn;
    logic [1:0] linkEn;
    logic [3:0] serialEn;
    logic dataEn;
    logic ackEn;
    logic readyEn;
    logic busMasterSelEn;
  } rcs_drive_t;
  localparam rcs_drive_t DRIVE_OFF = '0;
  typedef enum logic [1:0] {ST_RESET, ST_CORE_HOLD, ST_BUS_SYNC, ST_RUN} rcs_state_t;
endpackage

// ===== rtl/rcs_tick_div.sv
`timescale 1ns/100ps
module rcs_tick_div #(
  parameter int W = 4
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic run,
  input wire logic [W-1:0] divBy,
  output logic tick_r
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic tick_nxt;

  // one pulse every divBy cycles; zero or one means every cycle
  always_comb begin
    cnt_nxt = '0;
    tick_nxt = 1'b0;
    if (run) begin
      if (divBy <= W'(1) || cnt_r >= divBy - W'(1)) begin
        tick_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + W'(1);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end
endmodule

// ===== rtl/rcs_sequencer.sv
// Decided for this implementation: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps
module rcs_sequencer #(
  parameter int CORE_RST_TICKS = rcs_pkg::CORE_RST_TICKS,
  parameter int BUS_SYNC_TICKS = rcs_pkg::BUS_SYNC_TICKS,
  parameter int SER_DIV_W = rcs_pkg::SER_DIV_W
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [3:0] clockRatioCfgPins,
  input wire rcs_pkg::rcs_strobe_t coreStrobes,
  input wire rcs_pkg::rcs_drive_t coreDrive,
  input wire logic hostBusRequestN,
  input wire logic suspendBusTristateN,
  input wire logic multiprocessorMemorySpace,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output rcs_pkg::rcs_strobe_t pinStrobes,
  output rcs_pkg::rcs_drive_t pinDrive,
  output logic hostBusGrantN,
  output logic suspendAccepted,
  output logic memSpaceAccepted,
  output logic internalCoreResetN,
  output logic extPortTick,
  output logic [rcs_pkg::NUM_LINK-1:0] linkClkTick,
  output logic [rcs_pkg::NUM_SER-1:0] serialClkTick
);
  localparam int CNT_W = $clog2(CORE_RST_TICKS + 1);

  // ==========================================================
  // reset release synchroniser
  logic [rcs_pkg::RST_SYNC_STAGES-1:0] rstSync_r;
  logic [rcs_pkg::RST_SYNC_STAGES-1:0] rstSync_nxt;
  logic pinRstDone;

  always_comb begin
    rstSync_nxt = {rstSync_r[rcs_pkg::RST_SYNC_STAGES-2:0], 1'b1};
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rstSync_r <= '0;
    end else begin
      rstSync_r <= rstSync_nxt;
    end
  end
  assign pinRstDone = rstSync_r[rcs_pkg::RST_SYNC_STAGES-1];

  // ==========================================================
  // register file
  logic [31:0] sysCfg_r, sysCfg_nxt;
  logic [31:0] serDiv0_r, serDiv0_nxt;
  logic [31:0] serDiv1_r, serDiv1_nxt;
  logic awready_r, awready_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic arready_r, arready_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic softReset;
  logic resetActive;
  logic [31:0] statusWord;
  logic wrFire;
  logic rdFire;

  // state signals declared here, driven below
  rcs_pkg::rcs_state_t state_r, state_nxt;
  logic [2:0] ratio_r, ratio_nxt;
  logic hbrPending_r, hbrPending_nxt;

  function automatic logic [31:0] applyStrb(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] st);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction

  assign softReset = sysCfg_r[rcs_pkg::SOFT_RST_BIT];
  assign resetActive = !pinRstDone || softReset;
  assign statusWord = {24'h0, ratio_r, hbrPending_r, 1'b0, state_r == rcs_pkg::ST_RUN,
                       !internalCoreResetN, resetActive};
  assign wrFire = awready_r && s_axi_awvalid && s_axi_wvalid;
  assign rdFire = arready_r && s_axi_arvalid;

  always_comb begin
    sysCfg_nxt = sysCfg_r;
    serDiv0_nxt = serDiv0_r;
    serDiv1_nxt = serDiv1_r;
    bresp_nxt = bresp_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    awready_nxt = s_axi_awvalid && s_axi_wvalid && !awready_r && !bvalid_r;
    arready_nxt = s_axi_arvalid && !arready_r && !rvalid_r;
    bvalid_nxt = bvalid_r && !s_axi_bready;
    rvalid_nxt = rvalid_r && !s_axi_rready;
    if (wrFire) begin
      bvalid_nxt = 1'b1;
      bresp_nxt = rcs_pkg::RESP_OKAY;
      case (s_axi_awaddr)
        rcs_pkg::ADDR_SYSCFG: sysCfg_nxt = applyStrb(sysCfg_r, s_axi_wdata, s_axi_wstrb);
        rcs_pkg::ADDR_SERDIV0: serDiv0_nxt = applyStrb(serDiv0_r, s_axi_wdata, s_axi_wstrb);
        rcs_pkg::ADDR_SERDIV1: serDiv1_nxt = applyStrb(serDiv1_r, s_axi_wdata, s_axi_wstrb);
        rcs_pkg::ADDR_STATUS: bresp_nxt = rcs_pkg::RESP_OKAY;
        default: bresp_nxt = rcs_pkg::RESP_SLVERR;
      endcase
    end
    if (rdFire) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = rcs_pkg::RESP_OKAY;
      case (s_axi_araddr)
        rcs_pkg::ADDR_SYSCFG: rdata_nxt = sysCfg_r;
        rcs_pkg::ADDR_SERDIV0: rdata_nxt = serDiv0_r;
        rcs_pkg::ADDR_SERDIV1: rdata_nxt = serDiv1_r;
        rcs_pkg::ADDR_STATUS: rdata_nxt = statusWord;
        default: begin
          rdata_nxt = 32'h0000_0000;
          rresp_nxt = rcs_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sysCfg_r <= rcs_pkg::SYSCFG_RESET;
      serDiv0_r <= rcs_pkg::SERDIV_RESET;
      serDiv1_r <= rcs_pkg::SERDIV_RESET;
      awready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= rcs_pkg::RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rresp_r <= rcs_pkg::RESP_OKAY;
      rdata_r <= 32'h0000_0000;
    end else begin
      sysCfg_r <= sysCfg_nxt;
      serDiv0_r <= serDiv0_nxt;
      serDiv1_r <= serDiv1_nxt;
      awready_r <= awready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = awready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;

  // ==========================================================
  // reset sequencer and bus gating
  logic inTick;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic coreRstN_r, coreRstN_nxt;
  rcs_pkg::rcs_strobe_t strobes_r, strobes_nxt;
  rcs_pkg::rcs_drive_t drive_r, drive_nxt;
  logic grantN_r, grantN_nxt;
  logic suspAcc_r, suspAcc_nxt;
  logic mmsAcc_r, mmsAcc_nxt;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    ratio_nxt = ratio_r;
    hbrPending_nxt = hbrPending_r;
    if (!pinRstDone) begin
      case (clockRatioCfgPins[1:0])
        rcs_pkg::CFG_RATIO2: ratio_nxt = rcs_pkg::RATIO2;
        rcs_pkg::CFG_RATIO3: ratio_nxt = rcs_pkg::RATIO3;
        default: ratio_nxt = rcs_pkg::RATIO4;
      endcase
    end
    case (state_r)
      rcs_pkg::ST_RESET: begin
        cnt_nxt = '0;
        state_nxt = rcs_pkg::ST_CORE_HOLD;
      end
      rcs_pkg::ST_CORE_HOLD: begin
        if (inTick) begin
          if (cnt_r == CNT_W'(CORE_RST_TICKS - 1)) begin
            cnt_nxt = '0;
            state_nxt = rcs_pkg::ST_BUS_SYNC;
          end else begin
            cnt_nxt = cnt_r + CNT_W'(1);
          end
        end
      end
      rcs_pkg::ST_BUS_SYNC: begin
        if (inTick) begin
          if (cnt_r == CNT_W'(BUS_SYNC_TICKS - 1)) begin
            cnt_nxt = '0;
            state_nxt = rcs_pkg::ST_RUN;
          end else begin
            cnt_nxt = cnt_r + CNT_W'(1);
          end
        end
      end
      rcs_pkg::ST_RUN: cnt_nxt = '0;
      default: state_nxt = rcs_pkg::ST_RESET;
    endcase
    if (resetActive) begin
      state_nxt = rcs_pkg::ST_RESET;
      cnt_nxt = '0;
      if (!hostBusRequestN) begin
        hbrPending_nxt = 1'b1;
      end
    end else if (state_r == rcs_pkg::ST_RUN) begin
      hbrPending_nxt = 1'b0;
    end
    coreRstN_nxt = !resetActive && state_nxt != rcs_pkg::ST_RESET && state_nxt != rcs_pkg::ST_CORE_HOLD;
    strobes_nxt = resetActive ? rcs_pkg::STROBE_IDLE : coreStrobes;
    drive_nxt = resetActive ? rcs_pkg::DRIVE_OFF : coreDrive;
    grantN_nxt = !(!resetActive && state_r == rcs_pkg::ST_RUN && !hostBusRequestN);
    suspAcc_nxt = !resetActive && !suspendBusTristateN;
    mmsAcc_nxt = !resetActive && multiprocessorMemorySpace;
  end

  // pin reset drives outputs idle without waiting for a clock edge
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= rcs_pkg::ST_RESET;
      cnt_r <= '0;
      ratio_r <= rcs_pkg::RATIO2;
      hbrPending_r <= 1'b0;
      coreRstN_r <= 1'b0;
      strobes_r <= rcs_pkg::STROBE_IDLE;
      drive_r <= rcs_pkg::DRIVE_OFF;
      grantN_r <= 1'b1;
      suspAcc_r <= 1'b0;
      mmsAcc_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      ratio_r <= ratio_nxt;
      hbrPending_r <= hbrPending_nxt;
      coreRstN_r <= coreRstN_nxt;
      strobes_r <= strobes_nxt;
      drive_r <= drive_nxt;
      grantN_r <= grantN_nxt;
      suspAcc_r <= suspAcc_nxt;
      mmsAcc_r <= mmsAcc_nxt;
    end
  end

  assign internalCoreResetN = coreRstN_r;
  assign pinStrobes = strobes_r;
  assign pinDrive = drive_r;
  assign hostBusGrantN = grantN_r;
  assign suspendAccepted = suspAcc_r;
  assign memSpaceAccepted = mmsAcc_r;

  // ==========================================================
  // clock dividers
  rcs_tick_div #(.W(3)) u_inClk (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .run(1'b1),
    .divBy(ratio_r),
    .tick_r(inTick)
  );
  assign extPortTick = inTick;

  for (genvar g = 0; g < rcs_pkg::NUM_LINK; g++) begin : gLink
    logic [2:0] linkDivBy;
    assign linkDivBy = {1'b0, sysCfg_r[rcs_pkg::LINK_DIV_LSB + g*rcs_pkg::LINK_DIV_W +: 2]} + 3'h1;
    rcs_tick_div #(.W(3)) u_link (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .run(coreRstN_r),
      .divBy(linkDivBy),
      .tick_r(linkClkTick[g])
    );
  end

  for (genvar g = 0; g < rcs_pkg::NUM_SER; g++) begin : gSer
    logic [SER_DIV_W:0] serDivBy;
    logic [31:0] serWord;
    assign serWord = (g < 2) ? serDiv0_r : serDiv1_r;
    assign serDivBy = {1'b0, serWord[(g % 2)*16 +: SER_DIV_W]} + (SER_DIV_W+1)'(1);
    rcs_tick_div #(.W(SER_DIV_W+1)) u_ser (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .run(coreRstN_r),
      .divBy(serDivBy),
      .tick_r(serialClkTick[g])
    );
  end
endmodule

// ===== verif/rcs_sequencer_asserts.sv
`timescale 1ns/100ps
module rcs_sequencer_asserts #(
  parameter int CORE_RST_TICKS = 8
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [3:0] clockRatioCfgPins,
  input wire rcs_pkg::rcs_strobe_t coreStrobes,
  input wire rcs_pkg::rcs_drive_t coreDrive,
  input wire logic hostBusRequestN,
  input wire logic suspendBusTristateN,
  input wire logic multiprocessorMemorySpace,
  input wire rcs_pkg::rcs_strobe_t pinStrobes,
  input wire rcs_pkg::rcs_drive_t pinDrive,
  input wire logic hostBusGrantN,
  input wire logic suspendAccepted,
  input wire logic memSpaceAccepted,
  input wire logic internalCoreResetN,
  input wire logic extPortTick,
  input wire logic [rcs_pkg::NUM_LINK-1:0] linkClkTick,
  input wire logic [rcs_pkg::NUM_SER-1:0] serialClkTick
);
  logic [2:0] ratioExp;
  int gap;
  int holdTicks;
  logic seen;
  always_comb begin
    case (clockRatioCfgPins[1:0])
      rcs_pkg::CFG_RATIO2: ratioExp = rcs_pkg::RATIO2;
      rcs_pkg::CFG_RATIO3: ratioExp = rcs_pkg::RATIO3;
      default: ratioExp = rcs_pkg::RATIO4;
    endcase
  end
  // ==========================================================
  // tick spacing and core hold tick count
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      gap <= 0;
      holdTicks <= 0;
      seen <= 1'b0;
    end else begin
      gap <= extPortTick ? 1 : gap + 1;
      holdTicks <= internalCoreResetN ? 0 : holdTicks + int'(extPortTick);
      seen <= internalCoreResetN & (seen | extPortTick);
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // ==========================================================
  // properties
  a_idle_at_release: assert property ($rose(nrst) |-> pinStrobes == rcs_pkg::STROBE_IDLE &&
    pinDrive == rcs_pkg::DRIVE_OFF) else $error("outputs not idle at reset release");
  a_idle_when_reset: assert property ((!suspendBusTristateN ##1 !suspendAccepted) |->
    pinDrive == rcs_pkg::DRIVE_OFF && pinStrobes == rcs_pkg::STROBE_IDLE) else $error("pins driven in reset");
  a_pass_when_run: assert property (suspendAccepted |-> pinDrive == $past(coreDrive) &&
    pinStrobes == $past(coreStrobes)) else $error("pins do not follow core");
  a_suspend_cause: assert property (suspendAccepted |-> $past(suspendBusTristateN) == 1'b0)
    else $error("suspend accepted without request");
  a_memspace_cause: assert property (memSpaceAccepted |-> $past(multiprocessorMemorySpace))
    else $error("memory space accepted without request");
  a_grant_in_hold: assert property (!internalCoreResetN |-> hostBusGrantN)
    else $error("grant during core reset");
  a_grant_cause: assert property (!hostBusGrantN |-> !$past(hostBusRequestN) && internalCoreResetN)
    else $error("grant without request");
  a_core_hold_len: assert property ($rose(internalCoreResetN) |-> holdTicks >= CORE_RST_TICKS)
    else $error("core reset released early");
  a_ext_tick_rate: assert property (extPortTick && seen |-> gap == ratioExp)
    else $error("external port tick spacing wrong");
  a_tick_quiet: assert property (!internalCoreResetN && !$past(internalCoreResetN) |->
    linkClkTick == '0 && serialClkTick == '0) else $error("port ticks in core reset");
endmodule

bind rcs_sequencer rcs_sequencer_asserts #(.CORE_RST_TICKS(CORE_RST_TICKS)) u_rcs_sequencer_asserts (
  .ref_clk(ref_clk),
  .nrst(nrst),
  .clockRatioCfgPins(clockRatioCfgPins),
  .coreStrobes(coreStrobes),
  .coreDrive(coreDrive),
  .hostBusRequestN(hostBusRequestN),
  .suspendBusTristateN(suspendBusTristateN),
  .multiprocessorMemorySpace(multiprocessorMemorySpace),
  .pinStrobes(pinStrobes),
  .pinDrive(pinDrive),
  .hostBusGrantN(hostBusGrantN),
  .suspendAccepted(suspendAccepted),
  .memSpaceAccepted(memSpaceAccepted),
  .internalCoreResetN(internalCoreResetN),
  .extPortTick(extPortTick),
  .linkClkTick(linkClkTick),
  .serialClkTick(serialClkTick)
);

// ===== verif/rcs_board_model.sv
`timescale 1ns/100ps
module rcs_board_model (
  input wire logic ref_clk,
  input wire logic pulseReq,
  input wire logic [1:0] ratioCode,
  output logic nrst,
  output logic [3:0] clockRatioCfgPins
);
  int holdCnt;
  initial begin
    nrst = 1'b0;
    clockRatioCfgPins = 4'h0;
    holdCnt = 2;
  end
  // ratio pins set with reset and held until the next pulse
  always @(posedge ref_clk) begin
    if (pulseReq) begin
      nrst <= 1'b0;
      clockRatioCfgPins <= {ratioCode, ratioCode};
      holdCnt <= 16;
    end else if (holdCnt > 0) begin
      holdCnt <= holdCnt - 1;
      if (holdCnt == 1) begin
        nrst <= 1'b1;
      end
    end
  end
endmodule

// ===== verif/test_reset_and_clock_ratio_sequencer.sv
`timescale 1ns/100ps
module test_reset_and_clock_ratio_sequencer;
  localparam int TICKS = 8;
  localparam int SYNC = 2;
  logic ref_clk;
  logic nrst;
  logic pulseReq;
  logic [1:0] ratioCode;
  logic [3:0] cfgPins;
  rcs_pkg::rcs_strobe_t coreStrobes;
  rcs_pkg::rcs_drive_t coreDrive;
  rcs_pkg::rcs_strobe_t pinStrobes;
  rcs_pkg::rcs_drive_t pinDrive;
  logic hbrN, sbtsN, multiprocessor_memory_space, grantN, suspAcc, memAcc, coreRstN, extTick;
  logic [1:0] linkTick;
  logic [3:0] serTick;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp, rs;
  int error_cnt, total_checks, seed, n, r;
  int ex[6];
  wire logic [5:0] tk = {serTick, linkTick};
  rcs_board_model u_rcs_board_model (.ref_clk(ref_clk), .pulseReq(pulseReq), .ratioCode(ratioCode),
    .nrst(nrst), .clockRatioCfgPins(cfgPins));
  rcs_sequencer #(.CORE_RST_TICKS(TICKS), .BUS_SYNC_TICKS(SYNC)) u_rcs_sequencer (.ref_clk(ref_clk),
    .nrst(nrst), .clockRatioCfgPins(cfgPins), .coreStrobes(coreStrobes), .coreDrive(coreDrive),
    .hostBusRequestN(hbrN), .suspendBusTristateN(sbtsN), .multiprocessorMemorySpace(multiprocessor_memory_space),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pinStrobes(pinStrobes), .pinDrive(pinDrive), .hostBusGrantN(grantN),
    .suspendAccepted(suspAcc), .memSpaceAccepted(memAcc), .internalCoreResetN(coreRstN),
    .extPortTick(extTick), .linkClkTick(linkTick), .serialClkTick(serTick));
  // ==========================================================
  // checking and closing
  task automatic chk(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  task automatic conclude();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  function automatic int exp_ratio(input logic [1:0] c);
    return (c == rcs_pkg::CFG_RATIO2) ? 2 : (c == rcs_pkg::CFG_RATIO3) ? 3 : 4;
  endfunction
  // ==========================================================
  // bus master
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      k++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && k < 50);
    rs = bresp;
    bready <= 1'b0;
    chk(k < 50, "write timeout");
    @(posedge ref_clk);
  endtask
  task automatic axi_rd(input logic [7:0] a);
    int k;
    k = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      k++;
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && k < 50);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
    chk(k < 50, "read timeout");
  endtask
  task automatic wait_core();
    n = 0;
    while (coreRstN !== 1'b1 && n < 1000) begin
      @(posedge ref_clk);
      n++;
    end
  endtask
  task automatic wait_grant();
    n = 0;
    while (grantN !== 1'b0 && n < 200) begin
      @(posedge ref_clk);
      n++;
    end
  endtask
  task automatic tick_gap(input int sel, output int g);
    int k;
    k = 0;
    g = 0;
    while (tk[sel] !== 1'b1 && k < 100) begin
      @(posedge ref_clk);
      k++;
    end
    do begin
      @(posedge ref_clk);
      g++;
    end while (tk[sel] !== 1'b1 && g < 100);
  endtask
  // ==========================================================
  // clock, random core-side stimulus, watchdog
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    coreStrobes <= rcs_pkg::rcs_strobe_t'(12'($random(seed)));
    coreDrive <= rcs_pkg::rcs_drive_t'(14'($random(seed)));
    sbtsN <= 1'($random(seed));
    multiprocessor_memory_space <= 1'($random(seed));
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    conclude();
  end
  // ==========================================================
  // main sequence
  initial begin
    int g;
    logic [1:0] l0, l1;
    logic [3:0] s0, s1, s2, s3;
    seed = 32'hfabef615;
    error_cnt = 0;
    total_checks = 0;
    {pulseReq, ratioCode, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    hbrN = 1'b1;
    while (nrst !== 1'b1) @(posedge ref_clk);
    for (int c = 0; c < 4; c++) begin
      r = exp_ratio(2'(c));
      hbrN <= 1'b0;
      ratioCode <= 2'(c);
      pulseReq <= 1'b1;
      @(posedge ref_clk);
      pulseReq <= 1'b0;
      @(posedge ref_clk);
      while (nrst !== 1'b1) @(posedge ref_clk);
      wait_core();
      chk(n >= r * TICKS && n <= r * (TICKS + 1) + 4, "core reset length");
      wait_grant();
      chk(n >= SYNC * r && n <= (SYNC + 1) * r + 4, "grant after bus sync");
      axi_rd(rcs_pkg::ADDR_STATUS);
      chk(rd[7:5] === 3'(r), "ratio status");
      hbrN <= 1'b1;
      @(posedge ref_clk);
      @(posedge ref_clk);
      chk(grantN === 1'b1, "grant not released");
      l0 = 2'($random(seed));
      l1 = 2'($random(seed));
      s0 = 4'($random(seed));
      s1 = 4'($random(seed));
      s2 = 4'($random(seed));
      s3 = 4'($random(seed));
      ex = '{l0 + 1, l1 + 1, s0 + 1, s1 + 1, s2 + 1, s3 + 1};
      axi_wr(rcs_pkg::ADDR_SYSCFG, {24'h0, l1, l0, 4'h0});
      axi_wr(rcs_pkg::ADDR_SERDIV0, {12'h0, s1, 12'h0, s0});
      axi_wr(rcs_pkg::ADDR_SERDIV1, {12'h0, s3, 12'h0, s2});
      chk(rs === rcs_pkg::RESP_OKAY, "write response");
      for (int s = 0; s < 6; s++) begin
        tick_gap(s, g);
        tick_gap(s, g);
        chk(g == ex[s], "port clock divide");
      end
    end
    hbrN <= 1'b0;
    wait_grant();
    axi_wr(rcs_pkg::ADDR_SYSCFG, 32'h1);
    chk(coreRstN === 1'b0 && grantN === 1'b1 && suspAcc === 1'b0, "soft reset hold");
    chk(pinDrive === rcs_pkg::DRIVE_OFF && pinStrobes === rcs_pkg::STROBE_IDLE, "soft reset pins");
    axi_rd(rcs_pkg::ADDR_STATUS);
    chk(rd[0] === 1'b1, "reset status");
    axi_wr(rcs_pkg::ADDR_SYSCFG, 32'h0);
    wait_core();
    chk(n >= (TICKS - 1) * r && n <= r * (TICKS + 1) + 4, "soft core reset length");
    axi_rd(8'h40);
    chk(rs === rcs_pkg::RESP_SLVERR && rd === 32'h0, "unmapped read");
    axi_wr(8'h44, 32'h1);
    chk(rs === rcs_pkg::RESP_SLVERR && coreRstN === 1'b1, "unmapped write");
    conclude();
  end
endmodule
